// ==== src/ump_pkg.sv ====
// ump_pkg: constants for the multiprocessor serial control block
// assumes an 8-bit special-function register port on the core side
package ump_pkg;
   localparam logic [7:0] SERIAL_CTRL_ADDR = 8'h98;
   localparam logic [7:0] SERIAL_BUF_ADDR = 8'h99;
   localparam logic [7:0] SERIAL_MODE_ADDR = 8'hA9;
   localparam int OVR_BIT = 7;
   localparam int PERR_BIT = 6;
   localparam int THRE_BIT = 5;
   localparam int REN_BIT = 4;
   localparam int TBX_BIT = 3;
   localparam int RBX_BIT = 2;
   localparam int TI_BIT = 1;
   localparam int RI_BIT = 0;
   localparam int MCE_BIT = 7;
   localparam int PTYPE_HI = 6;
   localparam int PTYPE_LO = 5;
   localparam int PE_BIT = 4;
   localparam int XBE_BIT = 1;
   localparam logic [7:0] CTRL_RESET = 8'h20;
   localparam logic [7:0] MODE_RESET = 8'h0C;
   localparam int FIFO_DEPTH = 8;
   localparam int DATA_W = 8;
   localparam logic [1:0] PAR_ODD = 2'h0;
   localparam logic [1:0] PAR_EVEN = 2'h1;
   localparam logic [1:0] PAR_MARK = 2'h2;
   localparam logic [1:0] PAR_SPACE = 2'h3;
   typedef enum logic [1:0] {TX_IDLE, TX_SEND} ump_tx_state_t;
endpackage

// ==== src/ump_serial_ctrl.sv ====
// ump_serial_ctrl: control/status register, receive FIFO and extra-bit
// multiprocessor filter; assumes an outside shifter delivers received
// frames as strobes and takes transmit words with a ready handshake
`timescale 1ns/1ps
// Behaviour
// (RULE1) master sends address byte before data
// (RULE2) address extra bit 1, data 0
// (RULE3) filter on: done only if extra 1
// (RULE4) matching slave software clears filter
// (RULE5) filtered slave ignores following data bytes; code still pushes them into the FIFO, only done stays clear
// (RULE6) slave re-arms filter after message
// (RULE7) addresses may be shared or multiple
// (RULE8) overrun bit 7 set on full FIFO
// (RULE9) parity error bit 6, sticky until cleared
// (RULE10) holding-empty bit 5 read-only status
// (RULE11) software polls tx done, not holding-empty
// (RULE12) control at 0x98, reset reads 0x20
// (RULE13) filter at mode bit 7, needs extra
// (RULE14) transmit extra bit from tx field
// (RULE15) rx done set, held while FIFO data
// (RULE16) oldest byte extra bit shown readable
module ump_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] rd;
      logic [AW-1:0] wr;
      logic [AW:0] count;
   } ump_fifo_state_t;
   ump_fifo_state_t s, next_s;
   logic push, pop;
   always_comb
   begin
      next_s = s;
      push = in_valid && (s.count != (AW+1)'(DEPTH));
      pop = out_valid && out_ready;
      if (push)
      begin
         next_s.mem[s.wr] = in_data;
         next_s.wr = (s.wr == AW'(DEPTH-1)) ? '0 : s.wr + 1'b1;
      end
      if (pop)
         next_s.rd = (s.rd == AW'(DEPTH-1)) ? '0 : s.rd + 1'b1;
      if (push && !pop)
         next_s.count = s.count + 1'b1;
      else if (pop && !push)
         next_s.count = s.count - 1'b1;
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         s <= '0;
      else
         s <= next_s;
   end
   assign in_ready = (s.count != (AW+1)'(DEPTH));
   assign out_valid = (s.count != '0);
   assign out_data = s.mem[s.rd];
endmodule

module ump_serial_ctrl
   import ump_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // special-function register port
   input wire logic [7:0] SFR_ADDR,
   input wire logic SFR_WR,
   input wire logic SFR_RD,
   input wire logic [7:0] SFR_WDATA,
   output logic [7:0] SFR_RDATA,
   // received frame from the shifter
   input wire logic RX_FRAME,
   input wire logic [7:0] RX_DATA,
   input wire logic RX_NINTH,
   input wire logic RX_STOP_OK,
   // transmit word to the shifter
   output logic TX_VALID,
   input wire logic TX_READY,
   output logic [7:0] TX_DATA,
   output logic TX_NINTH,
   input wire logic TX_STOP_START,
   // mode outputs
   output logic RX_ENABLE,
   output logic EXTRA_EN,
   output logic PARITY_EN,
   output logic [1:0] PARITY_TYPE
);
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] mode;
      logic [7:0] txd;
      logic txn;
      ump_tx_state_t tx;
      logic [7:0] rdata;
      logic rx_f1;
      logic rx_f2;
      logic rx_f3;
      logic stop_f1;
      logic stop_f2;
      logic stop_f3;
   } ump_state_t;
   ump_state_t s, next_s;
   logic f_ready, f_valid, f_pop, f_push;
   logic [DATA_W+1:0] f_out, f_in;
   logic par_ok, expect_par, frame_evt, stop_evt;
   logic [7:0] rd_ctrl;
   // strobes come from the shifter's clock domain via a pin-level path
   ump_fifo #(.WIDTH(DATA_W+2), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(CLK),
      .rst_n(RST_N),
      .in_valid(f_push),
      .in_ready(f_ready),
      .in_data(f_in),
      .out_valid(f_valid),
      .out_ready(f_pop),
      .out_data(f_out)
   );
   assign frame_evt = s.rx_f2 && !s.rx_f3;
   assign stop_evt = s.stop_f2 && !s.stop_f3;
   // rx data held stable by the shifter while its frame strobe is high
   assign f_in = {RX_NINTH, RX_STOP_OK, RX_DATA};
   assign f_push = frame_evt && s.ctrl[REN_BIT] && RX_STOP_OK;
   assign f_pop = SFR_RD && (SFR_ADDR == SERIAL_BUF_ADDR) && f_valid;
   always_comb
   begin
      case (s.mode[PTYPE_HI:PTYPE_LO])
         PAR_ODD: expect_par = ~^f_out[7:0];
         PAR_EVEN: expect_par = ^f_out[7:0];
         PAR_MARK: expect_par = 1'b1;
         default: expect_par = 1'b0;
      endcase
      par_ok = (f_out[9] == expect_par);
   end
   always_comb
   begin
      rd_ctrl = s.ctrl;
      rd_ctrl[THRE_BIT] = (s.tx == TX_IDLE); // RULE10
      // extra bit of oldest byte, else its stop bit
      rd_ctrl[RBX_BIT] = s.mode[XBE_BIT] ? f_out[9] : f_out[8]; // RULE16
   end
   always_comb
   begin
      next_s = s;
      next_s.rx_f1 = RX_FRAME;
      next_s.rx_f2 = s.rx_f1;
      next_s.rx_f3 = s.rx_f2;
      next_s.stop_f1 = TX_STOP_START;
      next_s.stop_f2 = s.stop_f1;
      next_s.stop_f3 = s.stop_f2;
      next_s.rdata = 8'h00;
      if (SFR_RD)
      begin
         case (SFR_ADDR)
            SERIAL_CTRL_ADDR: next_s.rdata = rd_ctrl; // RULE12
            SERIAL_BUF_ADDR: next_s.rdata = f_out[7:0];
            SERIAL_MODE_ADDR: next_s.rdata = s.mode;
            default: next_s.rdata = 8'h00;
         endcase
      end
      if (SFR_WR)
      begin
         case (SFR_ADDR)
            SERIAL_CTRL_ADDR:
            begin
               next_s.ctrl = SFR_WDATA;
               next_s.ctrl[THRE_BIT] = 1'b0;
               next_s.ctrl[RBX_BIT] = 1'b0;
               // done stays set while FIFO holds data
               if (f_valid && s.ctrl[RI_BIT])
                  next_s.ctrl[RI_BIT] = 1'b1; // RULE15
            end
            SERIAL_MODE_ADDR: next_s.mode = SFR_WDATA; // RULE13
            SERIAL_BUF_ADDR:
            begin
               // a write while occupied is dropped, not corrupted
               if (s.tx == TX_IDLE)
               begin
                  next_s.txd = SFR_WDATA;
                  next_s.txn = s.ctrl[TBX_BIT]; // RULE14
                  next_s.tx = TX_SEND;
               end
            end
            default: next_s.ctrl = s.ctrl;
         endcase
      end
      // hardware sets win over software clears
      if (frame_evt && s.ctrl[REN_BIT] && RX_STOP_OK && !f_ready)
         next_s.ctrl[OVR_BIT] = 1'b1; // RULE8
      if (f_push && (!s.mode[MCE_BIT] || RX_NINTH))
         next_s.ctrl[RI_BIT] = 1'b1; // RULE3 RULE5 RULE2
      if (f_valid && s.mode[PE_BIT] && !par_ok)
         next_s.ctrl[PERR_BIT] = 1'b1; // RULE9
      if (stop_evt)
         next_s.ctrl[TI_BIT] = 1'b1;
      case (s.tx)
         TX_IDLE: next_s.tx = next_s.tx;
         TX_SEND:
            if (TX_READY)
               next_s.tx = TX_IDLE;
         default: next_s.tx = TX_IDLE;
      endcase
   end
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         s <= '0;
         s.ctrl <= CTRL_RESET & 8'hDF;
         s.mode <= MODE_RESET;
         s.tx <= TX_IDLE;
      end
      else
         s <= next_s;
   end
   assign SFR_RDATA = s.rdata;
   assign TX_VALID = (s.tx == TX_SEND);
   assign TX_DATA = s.txd;
   // parity field unused for extra bit while parity is on
   assign TX_NINTH = s.txn;
   assign RX_ENABLE = s.ctrl[REN_BIT];
   assign EXTRA_EN = s.mode[XBE_BIT];
   assign PARITY_EN = s.mode[PE_BIT];
   assign PARITY_TYPE = s.mode[PTYPE_HI:PTYPE_LO];
endmodule

// ==== testbench/ump_serial_ctrl_properties.sv ====
// ump_props: port assertions for the serial control block
// assumes a bind onto ump_serial_ctrl, ports named alike
`timescale 1ns/1ps
module ump_props (
   // clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // register port
   input wire logic [7:0] SFR_ADDR,
   input wire logic SFR_WR,
   input wire logic SFR_RD,
   input wire logic [7:0] SFR_WDATA,
   input wire logic [7:0] SFR_RDATA,
   // transmit and mode
   input wire logic TX_VALID,
   input wire logic TX_READY,
   input wire logic [7:0] TX_DATA,
   input wire logic RX_ENABLE,
   input wire logic [1:0] PARITY_TYPE
);
   default clocking @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   a_rdata_idle: assert property (!$past(SFR_RD) |-> !SFR_RDATA)
      else $error("read data not idle");
   a_thre_status: assert property (SFR_RD && SFR_ADDR == 8'h98
      |=> SFR_RDATA[5] == !$past(TX_VALID)) else $error("holding flag");
   a_tx_load: assert property (SFR_WR && SFR_ADDR == 8'h99 && !TX_VALID
      |=> TX_VALID && TX_DATA == $past(SFR_WDATA)) else $error("tx load");
   a_tx_hold: assert property (TX_VALID && !TX_READY
      |=> TX_VALID && $stable(TX_DATA)) else $error("tx hold");
   a_tx_release: assert property (TX_VALID && TX_READY |=> !TX_VALID)
      else $error("tx release");
   a_wr_refused: assert property (SFR_WR && TX_VALID && SFR_ADDR == 8'h99
      |=> TX_DATA == $past(TX_DATA)) else $error("busy write taken");
   a_ren_copy: assert property (SFR_WR && SFR_ADDR == 8'h98
      |-> ##2 RX_ENABLE == $past(SFR_WDATA[4], 2)) else $error("ren copy");
   a_ptype_copy: assert property (SFR_WR && SFR_ADDR == 8'hA9
      |-> ##2 PARITY_TYPE == $past(SFR_WDATA[6:5], 2)) else $error("ptype");
endmodule

bind ump_serial_ctrl ump_props ump_props_i (.CLK, .RST_N, .SFR_ADDR,
   .SFR_WR, .SFR_RD, .SFR_WDATA, .SFR_RDATA, .TX_VALID, .TX_READY,
   .TX_DATA, .RX_ENABLE, .PARITY_TYPE);

// ==== testbench/ump_shifter_model.sv ====
// ump_shifter_model: behavioural shifter on the serial side
// assumes the core samples its inputs at the rising clock edge
`timescale 1ns/1ps
module ump_shifter_model (
   // clock
   input wire logic CLK,
   // transmit side
   input wire logic TX_VALID,
   input wire logic [7:0] TX_DATA,
   input wire logic TX_NINTH,
   output logic TX_READY,
   output logic TX_STOP_START,
   // receive side
   output logic RX_FRAME,
   output logic [7:0] RX_DATA,
   output logic RX_NINTH,
   output logic RX_STOP_OK
);
   logic [8:0] got;
   initial
   begin
      {TX_READY, TX_STOP_START, RX_FRAME, RX_DATA, RX_NINTH, RX_STOP_OK} = '0;
      got = '0;
   end
   // stall taken from the data so that slow and prompt takes both occur
   always
   begin
      @(negedge CLK);
      if (TX_VALID)
      begin
         repeat (TX_DATA[1:0]) @(negedge CLK);
         got = {TX_NINTH, TX_DATA};
         TX_READY = 1'b1;
         @(negedge CLK);
         TX_READY = 1'b0;
         TX_STOP_START = 1'b1;
         repeat (4) @(negedge CLK);
         TX_STOP_START = 1'b0;
      end
   end
   // released lines show the inverse so stale values never look fresh
   task automatic send(input logic [7:0] d, input logic x, input logic ok);
      @(negedge CLK);
      {RX_DATA, RX_NINTH, RX_STOP_OK} = {d, x, ok};
      RX_FRAME = 1'b1;
      repeat (6) @(negedge CLK);
      RX_FRAME = 1'b0;
      {RX_DATA, RX_NINTH, RX_STOP_OK} = ~{d, x, ok};
      repeat (2) @(negedge CLK);
   endtask
endmodule

// ==== testbench/test_uart_multiprocessor_addressing.sv ====
// test_uart_multiprocessor_addressing: self-checking bench
// assumes the design, its package, checker and shifter model
`timescale 1ns/1ps
module test_uart_multiprocessor_addressing;
   logic CLK, RST_N, SFR_WR, SFR_RD, TX_VALID, TX_READY, TX_NINTH;
   logic TX_STOP_START, RX_FRAME, RX_NINTH, RX_STOP_OK, RX_ENABLE;
   logic EXTRA_EN, PARITY_EN;
   logic [7:0] SFR_ADDR, SFR_WDATA, SFR_RDATA, RX_DATA, TX_DATA, q, d;
   logic [1:0] PARITY_TYPE;
   logic [7:0] v [8];
   int errors, n_tests, seed, i;
   ump_serial_ctrl ump_serial_ctrl_i (.*);
   ump_shifter_model ump_shifter_model_i (.*);
   initial
   begin
      CLK = 1'b0;
      forever #50 CLK = ~CLK;
   end
   task automatic chk(input logic [8:0] s, input logic [8:0] e);
      n_tests++;
      if (s !== e)
      begin
         errors++;
         $display("Error at %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   // idle cycle after each write keeps mode copies apart
   task automatic wr(input logic [7:0] a, input logic [7:0] w);
      @(negedge CLK);
      {SFR_ADDR, SFR_WDATA, SFR_WR} = {a, w, 1'b1};
      @(negedge CLK);
      SFR_WR = 1'b0;
      @(negedge CLK);
   endtask
   task automatic rd(input logic [7:0] a);
      @(negedge CLK);
      {SFR_ADDR, SFR_RD} = {a, 1'b1};
      @(negedge CLK);
      q = SFR_RDATA;
      SFR_RD = 1'b0;
   endtask
   task automatic rx(input logic [7:0] b, input logic x);
      ump_shifter_model_i.send(b, x, 1'b1);
   endtask
   task automatic results;
      $display("errors %0d checks %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge CLK);
      errors++;
      results;
   end
   initial
   begin
      {RST_N, SFR_WR, SFR_RD, SFR_ADDR, SFR_WDATA, errors, n_tests} = '0;
      seed = 70946;
      repeat (6) @(negedge CLK);
      RST_N = 1'b1;
      rd(8'h98);
      chk(q, 8'h20);
      wr(8'hA9, 8'h0E);
      wr(8'h98, 8'h18);
      d = $random(seed);
      wr(8'h99, d);
      for (i = 0; i < 60 && q[1] !== 1'b1; i++) rd(8'h98);
      if (i == 60)
      begin
         errors++;
         results;
      end
      chk(ump_shifter_model_i.got, {1'b1, d});
      $display("transmit done");
      wr(8'hA9, 8'h8E);
      wr(8'h98, 8'h10);
      rx(d, 1'b0);
      rd(8'h98);
      chk(q & 8'h01, 8'h00);
      rx(8'h3C, 1'b1);
      rd(8'h98);
      chk(q & 8'h05, 8'h01);
      rd(8'h99);
      rd(8'h98);
      chk(q & 8'h04, 8'h04);
      rd(8'h99);
      chk(q, 8'h3C);
      wr(8'hA9, 8'h0E);
      wr(8'h98, 8'h10);
      rx(d, 1'b0);
      rd(8'h98);
      chk(q & 8'h01, 8'h01);
      rd(8'h99);
      $display("filter done");
      for (i = 0; i < 9; i++) rx(i < 8 ? (v[i] = $random(seed)) : d, 1'b0);
      rd(8'h98);
      chk(q & 8'h80, 8'h80);
      wr(8'h98, 8'h10);
      rd(8'h98);
      chk(q & 8'h81, 8'h01);
      for (i = 0; i < 8; i++) begin rd(8'h99); chk(q, v[i]); end
      $display("overrun done");
      wr(8'hA9, 8'h3C);
      rx(d, ~^d);
      rd(8'h98);
      rd(8'h98);
      chk(q & 8'h40, 8'h40);
      $display("parity done");
      results;
   end
endmodule
